// File: core/srw_supervisor.sv
// supply supervised reset generator with a pulse programmed watchdog
// assumes the supply comparator, refresh and inhibit inputs are synchronous to REF_CLK_IN
// How it works
// - from power-up the host reset output stays low until the power-up delay has run out.
// - the 128 us power-up delay starts once the supply sense input reports the supply good.
// - when the delay runs out the host reset output goes high and the host may run.
// - a supply fault pulls the reset low for 128 us and it rises only once the supply is good.
// - the watchdog period can be anything above 1 ms up to 10 s.
// - the host must refresh within each period, else the watchdog resets the host.
// - the width of the first refresh pulse, between 1 ms and 10 s, becomes the period.
// - with no programming pulse the period is 10 s and its expiry resets the host.
// - every watchdog reset puts the 10 s default back and forgets the programmed period.
// - while the inhibit input is high the watchdog never resets the host.
`timescale 1ns/1ns
`include "srw_regs.svh"

module srw_supervisor #(
	parameter logic [16:0] WD_DEFAULT_TICKS = 17'(`SRW_WD_MAX_TICKS),
	parameter logic [16:0] WD_MIN_TICKS = 17'(`SRW_WD_MIN_TICKS)
) (
	input wire logic REF_CLK_IN,
	input wire logic RST_IN,
	input wire logic SUPPLY_SENSE_IN,
	input wire logic WATCHDOG_REFRESH_IN,
	input wire logic WATCHDOG_INHIBIT_IN,
	output logic HOST_RESET_N_OUT,
	output logic WATCHDOG_PROGRAMMED_OUT
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	srw_pkg::srw_state_type state_q;
	srw_pkg::srw_state_type state_d;
	logic host_reset_n_q;
	logic [`SRW_TICK_CNT_W-1:0] div_q;
	logic tick;
	logic refresh_q;
	logic refresh_rise;
	logic refresh_fall;
	srw_pkg::srw_ticks_type width_q;
	srw_pkg::srw_ticks_type elapsed_q;
	srw_pkg::srw_ticks_type period_q;
	logic prog_q;
	logic wd_running;
	logic wd_fire;
	logic prog_pulse;
	logic timer_start;
	logic timer_abort;
	logic timer_busy;
	logic timer_done;

	// saturating tick increment, shared by width and elapsed counters
	function automatic srw_pkg::srw_ticks_type tick_inc(input srw_pkg::srw_ticks_type v);
		if (v == 17'h1ffff) begin
			return v;
		end
		return v + 17'h00001;
	endfunction

	// ----------------------------------------------------------------
	// timebase
	// ----------------------------------------------------------------
	// free running divider, one enable pulse every 100 us
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN || tick) begin
			div_q <= 10'h000;
		end else begin
			div_q <= div_q + 10'h001;
		end
	end

	assign tick = (div_q == 10'(`SRW_TICK_CYCLES - 1));

	// ----------------------------------------------------------------
	// supervisor state machine
	// ----------------------------------------------------------------
	// next state from supply level, delay timer and watchdog expiry
	always_comb begin
		state_d = state_q;
		case (state_q)
			srw_pkg::ST_OFF: begin
				if (SUPPLY_SENSE_IN) begin
					state_d = srw_pkg::ST_DELAY;
				end
			end
			srw_pkg::ST_DELAY: begin
				if (!SUPPLY_SENSE_IN) begin
					state_d = srw_pkg::ST_OFF;
				end else if (timer_done) begin
					state_d = srw_pkg::ST_RUN;
				end
			end
			srw_pkg::ST_RUN: begin
				if (!SUPPLY_SENSE_IN) begin
					state_d = srw_pkg::ST_HOLD;
				end else if (wd_fire) begin
					state_d = srw_pkg::ST_HOLD;
				end
			end
			srw_pkg::ST_HOLD: begin
				if (timer_done) begin
					// release only with the supply good again
					state_d = SUPPLY_SENSE_IN ? srw_pkg::ST_RUN : srw_pkg::ST_OFF;
				end
			end
			default: begin
				state_d = srw_pkg::ST_OFF;
			end
		endcase
	end

	// state register; power-up reset lands in the off state
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			state_q <= srw_pkg::ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// host reset output, high only while running
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			host_reset_n_q <= `SRW_RESET_N_RST;
		end else begin
			host_reset_n_q <= (state_d == srw_pkg::ST_RUN);
		end
	end

	assign HOST_RESET_N_OUT = host_reset_n_q;

	// ----------------------------------------------------------------
	// delay and hold timer
	// ----------------------------------------------------------------
	// start on every entry into delay or hold, abort when the delay loses supply
	assign timer_start = (state_q != state_d) &&
		((state_d == srw_pkg::ST_DELAY) || (state_d == srw_pkg::ST_HOLD));
	assign timer_abort = (state_q == srw_pkg::ST_DELAY) && !SUPPLY_SENSE_IN;

	srw_hold_timer u_hold_timer (
		.clk_in(REF_CLK_IN),
		.rst_in(RST_IN),
		.start_in(timer_start),
		.abort_in(timer_abort),
		.busy_out(timer_busy),
		.done_out(timer_done)
	);

	// ----------------------------------------------------------------
	// refresh pulse measurement
	// ----------------------------------------------------------------
	// previous refresh level for edge detection
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			refresh_q <= 1'b0;
		end else begin
			refresh_q <= WATCHDOG_REFRESH_IN;
		end
	end

	assign refresh_rise = WATCHDOG_REFRESH_IN && !refresh_q;
	assign refresh_fall = !WATCHDOG_REFRESH_IN && refresh_q; // refresh counts at pulse end

	// pulse width in ticks while the pin is high
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN || refresh_rise) begin
			width_q <= 17'h00000;
		end else if (refresh_q && tick) begin
			width_q <= tick_inc(width_q);
		end
	end

	// first pulse strictly inside the window sets the period
	assign prog_pulse = refresh_fall && !prog_q &&
		(width_q > WD_MIN_TICKS) && (width_q < WD_DEFAULT_TICKS);

	// ----------------------------------------------------------------
	// watchdog period
	// ----------------------------------------------------------------
	// default after power-up and after every watchdog reset
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN) begin
			period_q <= WD_DEFAULT_TICKS;
			prog_q <= `SRW_PROG_RST;
		end else if (wd_fire) begin
			period_q <= WD_DEFAULT_TICKS;
			prog_q <= 1'b0;
		end else if (prog_pulse) begin
			period_q <= width_q;
			prog_q <= 1'b1;
		end
	end

	assign WATCHDOG_PROGRAMMED_OUT = prog_q;

	// ----------------------------------------------------------------
	// watchdog timeout
	// ----------------------------------------------------------------
	// counting only while the host runs and the watchdog is not inhibited
	assign wd_running = (state_q == srw_pkg::ST_RUN) && !WATCHDOG_INHIBIT_IN;

	// ticks since the last refresh
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN || !wd_running || refresh_fall) begin
			elapsed_q <= 17'h00000;
		end else if (tick && (elapsed_q < period_q)) begin
			elapsed_q <= tick_inc(elapsed_q);
		end
	end

	// a refresh in the expiry cycle still saves the host
	assign wd_fire = wd_running && SUPPLY_SENSE_IN && !refresh_fall &&
		(elapsed_q >= period_q);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK_IN);
	endclocking

	default disable iff (RST_IN);

	logic [`SRW_AGE_CNT_W-1:0] age_q;

	// cycles since the timer was last started
	always_ff @(posedge REF_CLK_IN) begin
		if (RST_IN || timer_start) begin
			age_q <= 12'h000;
		end else if (age_q != 12'hfff) begin
			age_q <= age_q + 12'h001;
		end
	end

	sequence wd_expire_s;
		wd_running && SUPPLY_SENSE_IN && !refresh_fall && (elapsed_q >= period_q);
	endsequence

	sequence hold_low_s;
		(state_q == srw_pkg::ST_HOLD) && !HOST_RESET_N_OUT;
	endsequence

	sequence prog_pulse_s;
		refresh_fall && !prog_q && (width_q > WD_MIN_TICKS) && (width_q < WD_DEFAULT_TICKS);
	endsequence

	off_reset_low_a: assert property (
		(state_q == srw_pkg::ST_OFF) |-> !HOST_RESET_N_OUT
	) else $error("host reset high while supply off");

	delay_start_a: assert property (
		(state_q == srw_pkg::ST_OFF) && SUPPLY_SENSE_IN |=>
		(state_q == srw_pkg::ST_DELAY) && timer_busy && (age_q == 12'h000)
	) else $error("power-up delay not started on good supply");

	delay_length_a: assert property (
		timer_done |-> (age_q == 12'(`SRW_HOLD_CYCLES - 1))
	) else $error("delay or hold timer length wrong");

	release_cause_a: assert property (
		$rose(HOST_RESET_N_OUT) |-> $past(timer_done) && $past(SUPPLY_SENSE_IN)
	) else $error("host reset released without timer expiry");

	supply_fault_a: assert property (
		(state_q == srw_pkg::ST_RUN) && !SUPPLY_SENSE_IN |=> hold_low_s [*8]
	) else $error("supply fault did not hold reset low");

	period_bounds_a: assert property (
		(period_q > WD_MIN_TICKS) && (period_q <= WD_DEFAULT_TICKS)
	) else $error("watchdog period out of range");

	wd_timeout_a: assert property (
		wd_expire_s |=> hold_low_s ##1 hold_low_s
	) else $error("watchdog expiry did not reset host");

	prog_period_a: assert property (
		prog_pulse_s |=> prog_q && (period_q == $past(width_q))
	) else $error("programming pulse width not taken");

	default_period_a: assert property (
		!prog_q |-> (period_q == WD_DEFAULT_TICKS)
	) else $error("unprogrammed watchdog not at default");

	wd_reload_a: assert property (
		wd_fire |=> !prog_q && (period_q == WD_DEFAULT_TICKS)
	) else $error("default period not restored on watchdog reset");

	// inhibit blocks the expiry at once and has the counter cleared by the next cycle
	inhibit_block_a: assert property (
		WATCHDOG_INHIBIT_IN |-> !wd_fire ##1 (elapsed_q == 17'h00000)
	) else $error("watchdog active while inhibited");

	// every release comes a full hold after the timer was started
	wd_hold_len_a: assert property (
		$rose(HOST_RESET_N_OUT) |-> (age_q == 12'(`SRW_HOLD_CYCLES))
	) else $error("reset released before the hold ran out");

	hold_exit_a: assert property (
		(state_q == srw_pkg::ST_HOLD) && (state_d != srw_pkg::ST_HOLD) |->
		timer_done && (age_q == 12'(`SRW_HOLD_CYCLES - 1))
	) else $error("hold left before 128 us");

	delay_abort_a: assert property (
		(state_q == srw_pkg::ST_DELAY) && !SUPPLY_SENSE_IN |=>
		(state_q == srw_pkg::ST_OFF) && !timer_busy && !HOST_RESET_N_OUT
	) else $error("power-up delay not abandoned on supply drop");

endmodule

// File: core/srw_regs.svh
// constants of the supply reset and watchdog block: timing figures and reset values
// assumes a 10 MHz reference clock; included by bare name from core/
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define SRW_CLK_PERIOD_NS 100

// ----------------------------------------------------------------
// reset hold and power-up delay
// ----------------------------------------------------------------
`define SRW_HOLD_TIME_NS 128000
`define SRW_HOLD_CYCLES ((`SRW_HOLD_TIME_NS + `SRW_CLK_PERIOD_NS - 1) / `SRW_CLK_PERIOD_NS)
`define SRW_HOLD_CNT_W 11
`define SRW_AGE_CNT_W 12

// ----------------------------------------------------------------
// watchdog timebase, one tick per 100 us
// ----------------------------------------------------------------
`define SRW_TICK_TIME_NS 100000
`define SRW_TICK_CYCLES (`SRW_TICK_TIME_NS / `SRW_CLK_PERIOD_NS)
`define SRW_TICK_CNT_W 10
`define SRW_TICKS_W 17

// ----------------------------------------------------------------
// watchdog period limits
// ----------------------------------------------------------------
`define SRW_WD_MIN_TIME_US 1000
`define SRW_WD_MIN_TICKS ((`SRW_WD_MIN_TIME_US * 1000 + `SRW_TICK_TIME_NS - 1) / `SRW_TICK_TIME_NS)
`define SRW_WD_MAX_TIME_MS 10000
`define SRW_WD_MAX_TICKS (64'(`SRW_WD_MAX_TIME_MS) * 64'd1000000 / 64'(`SRW_TICK_TIME_NS))

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SRW_RESET_N_RST 1'b0
`define SRW_PROG_RST 1'b0

`endif

// File: core/srw_pkg.sv
// types of the supply reset and watchdog block
// assumes nothing beyond a SystemVerilog compiler
package srw_pkg;

	// ----------------------------------------------------------------
	// supervisor states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_DELAY = 2'b01,
		ST_RUN = 2'b10,
		ST_HOLD = 2'b11
	} srw_state_type;

	// watchdog time in 100 us ticks
	typedef logic [16:0] srw_ticks_type;

endpackage

// File: core/srw_hold_timer.sv
// fixed 128 us countdown used for the power-up delay and the reset hold
// assumes one synchronous active-high reset and the 10 MHz clock
`timescale 1ns/1ns
`include "srw_regs.svh"

module srw_hold_timer (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic abort_in,
	output logic busy_out,
	output logic done_out
);

	logic [`SRW_HOLD_CNT_W-1:0] cnt_q;
	logic busy_q;

	// ----------------------------------------------------------------
	// countdown
	// ----------------------------------------------------------------
	// load on start, stop on abort or after the last cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_q <= 11'h000;
			busy_q <= 1'b0;
		end else if (start_in) begin
			cnt_q <= 11'(`SRW_HOLD_CYCLES);
			busy_q <= 1'b1;
		end else if (abort_in || done_out) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 11'h001;
		end
	end

	assign busy_out = busy_q;
	assign done_out = busy_q && !abort_in && (cnt_q == 11'h001); // last cycle of the run

endmodule

// File: test/srw_host_model.sv
// host side partner: drives the watchdog refresh line of the supervisor
// assumes the bench calls send_pulse from its own process, one pulse at a time
`timescale 1ns/1ns

module srw_host_model (
	input wire logic clk_in,
	input wire logic host_reset_n_in,
	output logic refresh_out
);
	// ----------------------------------------------------------------
	// refresh pulses
	// ----------------------------------------------------------------
	// idle low from time zero
	initial begin
		refresh_out = 1'b0;
	end

	// one high pulse of width cycles, launched and ended after rising edges
	task automatic send_pulse(input int width);
		@(posedge clk_in);
		// a host held in reset cannot pulse its pin
		while (host_reset_n_in !== 1'b1) begin
			@(posedge clk_in);
		end
		refresh_out <= 1'b1;
		repeat (width) @(posedge clk_in);
		refresh_out <= 1'b0;
		@(posedge clk_in);
	endtask
endmodule

// File: test/supply_reset_and_watchdog_tb.sv
// self-checking bench of the supply reset and watchdog supervisor
// assumes shortened watchdog counts: default 20 ticks, minimum 3 ticks of 1000 cycles
`timescale 1ns/1ns

module supply_reset_and_watchdog_tb;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic sense = 1'b0;
	logic inhibit = 1'b0;
	logic refresh;
	logic host_reset_n;
	logic programmed;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int low_cnt = 0;

	srw_supervisor #(
		.WD_DEFAULT_TICKS(17'h00014),
		.WD_MIN_TICKS(17'h00003)
	) u_dut (
		.REF_CLK_IN(ref_clk),
		.RST_IN(rst),
		.SUPPLY_SENSE_IN(sense),
		.WATCHDOG_REFRESH_IN(refresh),
		.WATCHDOG_INHIBIT_IN(inhibit),
		.HOST_RESET_N_OUT(host_reset_n),
		.WATCHDOG_PROGRAMMED_OUT(programmed)
	);

	srw_host_model u_host (
		.clk_in(ref_clk),
		.host_reset_n_in(host_reset_n),
		.refresh_out(refresh)
	);

	// ----------------------------------------------------------------
	// clock, cycle ceiling and reset activity count
	// ----------------------------------------------------------------
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	// count cycles with reset low, and cut a hang short
	always @(posedge ref_clk) begin
		cycles++;
		if (host_reset_n === 1'b0) low_cnt++;
		if (cycles == 100000) begin
			errors++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// wait for the reset output to reach a level; must take lo..hi cycles
	task automatic expect_edge(input logic level, input int lo, input int hi);
		int n;
		n = 0;
		while (host_reset_n !== level && n <= hi) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		check({31'h0, n >= lo && n <= hi}, 32'h1);
	endtask

	task automatic set_sense(input logic v);
		@(posedge ref_clk);
		sense <= v;
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// power-up: low through the whole delay, then high
	task automatic t_powerup();
		check({31'h0, host_reset_n}, 32'h0);
		set_sense(1'b1);
		expect_edge(1'b1, 1278, 1284);
	endtask

	// supply faults: fixed hold, and a dip that abandons the delay
	task automatic t_supply();
		set_sense(1'b0);
		repeat (10) @(posedge ref_clk);
		sense <= 1'b1;
		#1;
		check({31'h0, host_reset_n}, 32'h0);
		expect_edge(1'b1, 1265, 1275);
		set_sense(1'b0);
		repeat (1400) @(posedge ref_clk);
		sense <= 1'b1;
		repeat (600) @(posedge ref_clk);
		sense <= 1'b0;
		repeat (10) @(posedge ref_clk);
		sense <= 1'b1;
		expect_edge(1'b1, 1278, 1284);
	endtask

	// programmed period, refreshes, expiry, then the restored default
	task automatic t_watchdog();
		int base;
		u_host.send_pulse(8000);
		#1;
		check({31'h0, programmed}, 32'h1);
		base = low_cnt;
		repeat (3) begin
			repeat (5000) @(posedge ref_clk);
			u_host.send_pulse(100);
		end
		check(low_cnt, base);
		expect_edge(1'b0, 5500, 9500);
		repeat (2) @(posedge ref_clk);
		#1;
		check({31'h0, programmed}, 32'h0);
		expect_edge(1'b1, 1276, 1282);
		expect_edge(1'b0, 18500, 21500);
		expect_edge(1'b1, 1276, 1282);
	endtask

	// inhibit: no watchdog reset, supply reset still works
	task automatic t_inhibit();
		int base;
		@(posedge ref_clk);
		inhibit <= 1'b1;
		base = low_cnt;
		// a pulse of exactly the minimum width is only a refresh
		u_host.send_pulse(3000);
		#1;
		check({31'h0, programmed}, 32'h0);
		repeat (22000) @(posedge ref_clk);
		check(low_cnt, base);
		set_sense(1'b0);
		expect_edge(1'b0, 1, 3);
		set_sense(1'b1);
		expect_edge(1'b1, 1265, 1284);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		t_powerup();
		t_supply();
		t_watchdog();
		t_inhibit();
		final_report();
	end
endmodule
